/* verilog/bcsu_unit.sv */
// Branch, call and stack execution unit of a 4-bit core
`timescale 1ns/1ps
module bcsu_unit (
  input  wire logic             ref_clk,
  input  wire logic             srst,
  input  wire logic             cmdValid,
  input  bcsu_pkg::bcsu_op_type cmdOp,
  output logic                  cmdReady,
  input  wire logic [13:0]      immAddr,
  input  wire logic [13:0]      curAddr,
  input  wire logic [13:0]      nextAddr,
  input  wire logic [5:0]       relDisp,
  input  wire logic             memBit,
  input  wire logic [3:0]       regB,
  input  wire logic [3:0]       regC,
  input  wire logic [3:0]       regD,
  input  wire logic [3:0]       regE,
  input  wire logic [3:0]       regX,
  input  wire logic [3:0]       regA,
  input  wire logic [3:0]       pushHigh,
  input  wire logic [3:0]       pushLow,
  input  wire logic [3:0]       memoryBankSelect,
  input  wire logic [1:0]       registerBankSelect,
  input  wire logic             frameModeTwo,
  input  wire logic             statusLoad,
  input  wire logic [3:0]       statusLoadHigh,
  input  wire logic [3:0]       statusLoadLow,
  output logic [13:0]           instructionPointer,
  output logic [7:0]            stackPointer,
  output logic [3:0]            statusWordHigh,
  output logic [3:0]            statusWordLow,
  output logic                  carryFlag,
  output logic                  memoryBankEnable,
  output logic                  registerBankEnable,
  output logic [7:0]            memAddr,
  output logic [3:0]            memWrData,
  output logic                  memWrite,
  output logic                  memRead,
  input  wire logic [3:0]       memRdData,
  output logic                  done,
  output logic                  skipNext,
  output logic                  pairLoad,
  output logic [3:0]            pairHigh,
  output logic [3:0]            pairLow
);

  typedef struct packed {
    bcsu_pkg::bcsu_fsm_type st;
    logic                   ready;
    bcsu_pkg::bcsu_op_type  op;
    logic [13:0]            ip;
    logic [13:0]            target;
    logic [7:0]             stackPtr;
    logic [3:0]             swHigh;
    logic [3:0]             swLow;
    logic [2:0]             idx;
    logic [2:0]             count;
    logic [1:0]             firstOff;
    logic [2:0]             step;
    logic                   modeTwo;
    logic [23:0]            frame;
    logic [7:0]             memAddr;
    logic [3:0]             memWrData;
    logic                   memWrite;
    logic                   memRead;
    logic                   done;
    logic                   skipNext;
    logic                   pairLoad;
    logic [3:0]             pairHigh;
    logic [3:0]             pairLow;
  } bcsu_regs_type;

  bcsu_regs_type cur;
  bcsu_regs_type next_cur;

  logic [13:0] calcTarget;
  logic [23:0] buildFrame;
  logic [1:0]  buildOff;
  logic [2:0]  buildCount;
  logic        accept;
  logic [23:0] rb;

  bcsu_target_calc u_target (
    .op       (cmdOp),
    .immAddr  (immAddr),
    .curAddr  (curAddr),
    .nextAddr (nextAddr),
    .relDisp  (relDisp),
    .regB     (regB),
    .regC     (regC),
    .regD     (regD),
    .regE     (regE),
    .regX     (regX),
    .regA     (regA),
    .target   (calcTarget)
  );

  bcsu_frame_builder u_frame (
    .op       (cmdOp),
    .modeTwo  (frameModeTwo),
    .retAddr  (nextAddr),
    .memEn    (cur.swLow[bcsu_pkg::SW_MEM_EN_BIT]),
    .regEn    (cur.swLow[bcsu_pkg::SW_REG_EN_BIT]),
    .pairHigh (pushHigh),
    .pairLow  (pushLow),
    .memSel   (memoryBankSelect),
    .regSel   (registerBankSelect),
    .frame    (buildFrame),
    .firstOff (buildOff),
    .count    (buildCount)
  );

  assign accept = cmdValid && (cur.st == bcsu_pkg::ST_IDLE);

  always_comb begin
    next_cur          = cur;
    next_cur.memWrite = 1'b0;
    next_cur.memRead  = 1'b0;
    next_cur.done     = 1'b0;
    next_cur.skipNext = 1'b0;
    next_cur.pairLoad = 1'b0;
    rb                = cur.frame;
    rb[{cur.idx, 2'b00} +: 4] = memRdData;
    if (statusLoad && cur.st == bcsu_pkg::ST_IDLE) begin
      next_cur.swHigh = statusLoadHigh;
      next_cur.swLow  = statusLoadLow;
    end
    case (cur.st)
      bcsu_pkg::ST_IDLE: begin
        if (accept) begin
          next_cur.op       = cmdOp;
          next_cur.target   = calcTarget;
          next_cur.modeTwo  = frameModeTwo;
          next_cur.idx      = 3'h0;
          next_cur.frame    = buildFrame;
          next_cur.firstOff = buildOff;
          next_cur.count    = buildCount;
          case (cmdOp)
            bcsu_pkg::OP_XOR_CARRY: begin
              next_cur.swHigh[bcsu_pkg::SW_CARRY_BIT] =
                cur.swHigh[bcsu_pkg::SW_CARRY_BIT] ^ memBit;
              next_cur.done = 1'b1;
            end
            bcsu_pkg::OP_JUMP_ABS, bcsu_pkg::OP_JUMP_REL,
            bcsu_pkg::OP_JUMP_BLOCK, bcsu_pkg::OP_PAGE_DE,
            bcsu_pkg::OP_PAGE_XA, bcsu_pkg::OP_JUMP_BCDE,
            bcsu_pkg::OP_JUMP_BCXA: begin
              next_cur.ip   = calcTarget;
              next_cur.done = 1'b1;
            end
            bcsu_pkg::OP_CALL_FAR, bcsu_pkg::OP_CALL_FAST,
            bcsu_pkg::OP_PUSH_PAIR, bcsu_pkg::OP_PUSH_BANKS: begin
              next_cur.st = bcsu_pkg::ST_PUSH;
            end
            bcsu_pkg::OP_EXIT, bcsu_pkg::OP_EXIT_SKIP: begin
              next_cur.st    = bcsu_pkg::ST_ADDR;
              next_cur.count = frameModeTwo ? 3'h5 : 3'h4;
              next_cur.step  = frameModeTwo ? bcsu_pkg::STEP_MODE2
                                            : bcsu_pkg::STEP_MODE1;
            end
            bcsu_pkg::OP_EXIT_INT: begin
              next_cur.st    = bcsu_pkg::ST_ADDR;
              next_cur.count = 3'h6;
              next_cur.step  = bcsu_pkg::STEP_MODE2;
            end
            bcsu_pkg::OP_POP_PAIR: begin
              next_cur.st    = bcsu_pkg::ST_ADDR;
              next_cur.count = 3'h2;
              next_cur.step  = bcsu_pkg::STEP_PAIR;
            end
            default: begin
              next_cur.done = 1'b1;
            end
          endcase
        end
      end
      bcsu_pkg::ST_PUSH: begin
        next_cur.memWrite  = 1'b1;
        next_cur.memAddr   = cur.stackPtr - {6'h00, cur.firstOff}
                             - {5'h00, cur.idx};
        next_cur.memWrData = cur.frame[{cur.idx, 2'b00} +: 4];
        next_cur.idx       = cur.idx + 3'h1;
        if (cur.idx == cur.count - 3'h1) begin
          next_cur.st       = bcsu_pkg::ST_IDLE;
          next_cur.done     = 1'b1;
          next_cur.stackPtr = cur.stackPtr - {6'h00, cur.firstOff}
                              - {5'h00, cur.count} + 8'h01;
          if (cur.op == bcsu_pkg::OP_CALL_FAR || cur.op == bcsu_pkg::OP_CALL_FAST) begin
            next_cur.ip = cur.target;
          end
        end
      end
      bcsu_pkg::ST_ADDR: begin
        next_cur.memRead = 1'b1;
        next_cur.memAddr = cur.stackPtr + {5'h00, cur.idx};
        next_cur.st      = bcsu_pkg::ST_WAIT;
      end
      bcsu_pkg::ST_WAIT: begin
        next_cur.st = bcsu_pkg::ST_TAKE;
      end
      bcsu_pkg::ST_TAKE: begin
        next_cur.frame = rb;
        next_cur.idx   = cur.idx + 3'h1;
        next_cur.st    = bcsu_pkg::ST_ADDR;
        if (cur.idx == cur.count - 3'h1) begin
          next_cur.st       = bcsu_pkg::ST_IDLE;
          next_cur.done     = 1'b1;
          next_cur.stackPtr = cur.stackPtr + {5'h00, cur.step};
          case (cur.op)
            bcsu_pkg::OP_EXIT, bcsu_pkg::OP_EXIT_SKIP: begin
              next_cur.ip = {rb[5:4], rb[3:0], rb[15:12], rb[11:8]};
              if (!cur.modeTwo) begin
                next_cur.swLow[bcsu_pkg::SW_MEM_EN_BIT] = rb[4 + bcsu_pkg::M1_MEM_EN_BIT];
                next_cur.swLow[bcsu_pkg::SW_REG_EN_BIT] = rb[4 + bcsu_pkg::M1_REG_EN_BIT];
              end else begin
                next_cur.swLow[bcsu_pkg::SW_MEM_EN_BIT] = rb[16 + bcsu_pkg::SW_MEM_EN_BIT];
                next_cur.swLow[bcsu_pkg::SW_REG_EN_BIT] = rb[16 + bcsu_pkg::SW_REG_EN_BIT];
              end
              next_cur.skipNext = (cur.op == bcsu_pkg::OP_EXIT_SKIP);
            end
            bcsu_pkg::OP_EXIT_INT: begin
              next_cur.ip     = {rb[5:4], rb[3:0], rb[15:12], rb[11:8]};
              next_cur.swLow  = rb[19:16];
              next_cur.swHigh = rb[23:20];
            end
            bcsu_pkg::OP_POP_PAIR: begin
              next_cur.pairLow  = rb[3:0];
              next_cur.pairHigh = rb[7:4];
              next_cur.pairLoad = 1'b1;
            end
            default: begin
              next_cur.done = 1'b1;
            end
          endcase
        end
      end
      default: begin
        next_cur.st = bcsu_pkg::ST_IDLE;
      end
    endcase
    next_cur.ready = (next_cur.st == bcsu_pkg::ST_IDLE);
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cur          <= '0;
      cur.st       <= bcsu_pkg::ST_IDLE;
      cur.ready    <= 1'b1;
      cur.op       <= bcsu_pkg::OP_NONE;
      cur.ip       <= bcsu_pkg::IP_RESET;
      cur.stackPtr <= bcsu_pkg::STACK_RESET;
      cur.swHigh   <= bcsu_pkg::SW_HIGH_RESET;
      cur.swLow    <= bcsu_pkg::SW_LOW_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  assign cmdReady           = cur.ready;
  assign instructionPointer = cur.ip;
  assign stackPointer       = cur.stackPtr;
  assign statusWordHigh     = cur.swHigh;
  assign statusWordLow      = cur.swLow;
  assign carryFlag          = cur.swHigh[bcsu_pkg::SW_CARRY_BIT];
  assign memoryBankEnable   = cur.swLow[bcsu_pkg::SW_MEM_EN_BIT];
  assign registerBankEnable = cur.swLow[bcsu_pkg::SW_REG_EN_BIT];
  assign memAddr            = cur.memAddr;
  assign memWrData          = cur.memWrData;
  assign memWrite           = cur.memWrite;
  assign memRead            = cur.memRead;
  assign done               = cur.done;
  assign skipNext           = cur.skipNext;
  assign pairLoad           = cur.pairLoad;
  assign pairHigh           = cur.pairHigh;
  assign pairLow            = cur.pairLow;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  a_carry_xor: assert property (
    accept && cmdOp == bcsu_pkg::OP_XOR_CARRY && !statusLoad
    |=> carryFlag == ($past(carryFlag) ^ $past(memBit)))
    else $error("carry xor result wrong");

  a_abs_jump: assert property (
    accept && cmdOp == bcsu_pkg::OP_JUMP_ABS
    |=> instructionPointer == $past(immAddr))
    else $error("absolute jump target wrong");

  a_block_jump: assert property (
    accept && cmdOp == bcsu_pkg::OP_JUMP_BLOCK
    |=> instructionPointer == {$past(nextAddr[13:12]), $past(immAddr[11:0])})
    else $error("block jump target wrong");

  a_page_de: assert property (
    accept && cmdOp == bcsu_pkg::OP_PAGE_DE
    |=> instructionPointer == {$past(nextAddr[13:8]), $past(regD), $past(regE)})
    else $error("page jump via de wrong");

  a_indirect_bcde: assert property (
    accept && cmdOp == bcsu_pkg::OP_JUMP_BCDE
    |=> instructionPointer[13:12] == $past(regB[1:0])
        && instructionPointer[3:0] == $past(regE))
    else $error("indirect jump target wrong");

  a_call_one: assert property (
    accept && cmdOp == bcsu_pkg::OP_CALL_FAR && !frameModeTwo
    |-> ##5 stackPointer == $past(stackPointer, 5) - 8'h04
        && instructionPointer == $past(immAddr, 5))
    else $error("mode one call wrong");

  a_call_two: assert property (
    accept && cmdOp == bcsu_pkg::OP_CALL_FAR && frameModeTwo
    |-> ##6 stackPointer == $past(stackPointer, 6) - 8'h06)
    else $error("mode two call depth wrong");

  a_push_high: assert property (
    accept && cmdOp == bcsu_pkg::OP_PUSH_PAIR
    |-> ##2 memWrite && memWrData == $past(pushHigh, 2)
        && memAddr == $past(stackPointer, 2) - 8'h01
        ##1 memWrite && memWrData == $past(pushLow, 3))
    else $error("pair push order wrong");

  a_exit_flags: assert property (
    cur.st != bcsu_pkg::ST_IDLE
    && (cur.op == bcsu_pkg::OP_EXIT || cur.op == bcsu_pkg::OP_EXIT_SKIP)
    |=> statusWordHigh == $past(statusWordHigh)
        && statusWordLow[3:2] == $past(statusWordLow[3:2]))
    else $error("return changed status flags");

  a_skip_pulse: assert property (
    skipNext |-> done && $past(cur.op) == bcsu_pkg::OP_EXIT_SKIP ##1 !skipNext)
    else $error("skip pulse without skipping return");

endmodule // bcsu_unit

/* verilog/bcsu_pkg.sv */
// Shared constants and types for the branch, call and stack unit
package bcsu_pkg;

  localparam int unsigned IP_WIDTH = 14;
  localparam int unsigned STACK_WIDTH = 8;
  localparam int unsigned NIB      = 4;
  localparam int unsigned FRAME_NIBS = 6;

  localparam logic [13:0] IP_RESET = 14'h0000;
  localparam logic [7:0]  STACK_RESET = 8'h00;
  localparam logic [3:0]  SW_LOW_RESET  = 4'h0;
  localparam logic [3:0]  SW_HIGH_RESET = 4'h0;

  // Status word field positions
  localparam int unsigned SW_CARRY_BIT = 3;
  localparam int unsigned SW_MEM_EN_BIT = 1;
  localparam int unsigned SW_REG_EN_BIT = 0;

  // Frame layout in the mode-one status nibble
  localparam int unsigned M1_MEM_EN_BIT = 3;
  localparam int unsigned M1_REG_EN_BIT = 2;

  // Stack pointer steps
  localparam logic [2:0] STEP_PAIR  = 3'h2;
  localparam logic [2:0] STEP_MODE1 = 3'h4;
  localparam logic [2:0] STEP_MODE2 = 3'h6;

  typedef enum logic [4:0] {
    OP_NONE        = 5'h00,
    OP_XOR_CARRY   = 5'h01,
    OP_JUMP_ABS    = 5'h02,
    OP_JUMP_REL    = 5'h03,
    OP_JUMP_BLOCK  = 5'h04,
    OP_PAGE_DE     = 5'h05,
    OP_PAGE_XA     = 5'h06,
    OP_JUMP_BCDE   = 5'h07,
    OP_JUMP_BCXA   = 5'h08,
    OP_CALL_FAR    = 5'h09,
    OP_CALL_FAST   = 5'h0A,
    OP_EXIT        = 5'h0B,
    OP_EXIT_SKIP   = 5'h0C,
    OP_EXIT_INT    = 5'h0D,
    OP_PUSH_PAIR   = 5'h0E,
    OP_PUSH_BANKS  = 5'h0F,
    OP_POP_PAIR    = 5'h10
  } bcsu_op_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PUSH = 3'b001,
    ST_ADDR = 3'b010,
    ST_WAIT = 3'b011,
    ST_TAKE = 3'b100
  } bcsu_fsm_type;

endpackage

/* verilog/bcsu_target_calc.sv */
// Branch and call target address former
`timescale 1ns/1ps
module bcsu_target_calc (
  input  bcsu_pkg::bcsu_op_type op,
  input  wire logic [13:0]      immAddr,
  input  wire logic [13:0]      curAddr,
  input  wire logic [13:0]      nextAddr,
  input  wire logic [5:0]       relDisp,
  input  wire logic [3:0]       regB,
  input  wire logic [3:0]       regC,
  input  wire logic [3:0]       regD,
  input  wire logic [3:0]       regE,
  input  wire logic [3:0]       regX,
  input  wire logic [3:0]       regA,
  output logic      [13:0]      target
);

  always_comb begin
    case (op)
      bcsu_pkg::OP_JUMP_ABS, bcsu_pkg::OP_CALL_FAR: begin
        target = immAddr;
      end
      bcsu_pkg::OP_JUMP_REL: begin
        target = curAddr + {{8{relDisp[5]}}, relDisp};
      end
      bcsu_pkg::OP_JUMP_BLOCK: begin
        target = {nextAddr[13:12], immAddr[11:0]};
      end
      bcsu_pkg::OP_PAGE_DE: begin
        target = {nextAddr[13:8], regD, regE};
      end
      bcsu_pkg::OP_PAGE_XA: begin
        target = {nextAddr[13:8], regX, regA};
      end
      bcsu_pkg::OP_JUMP_BCDE: begin
        target = {regB[1:0], regC, regD, regE};
      end
      bcsu_pkg::OP_JUMP_BCXA: begin
        target = {regB[1:0], regC, regX, regA};
      end
      bcsu_pkg::OP_CALL_FAST: begin
        target = {3'h0, immAddr[10:0]};
      end
      default: begin
        target = nextAddr;
      end
    endcase
  end

endmodule // bcsu_target_calc

/* verilog/bcsu_frame_builder.sv */
// Stack frame layout for calls and pushes
`timescale 1ns/1ps
module bcsu_frame_builder (
  input  bcsu_pkg::bcsu_op_type op,
  input  wire logic             modeTwo,
  input  wire logic [13:0]      retAddr,
  input  wire logic             memEn,
  input  wire logic             regEn,
  input  wire logic [3:0]       pairHigh,
  input  wire logic [3:0]       pairLow,
  input  wire logic [3:0]       memSel,
  input  wire logic [1:0]       regSel,
  output logic      [23:0]      frame,
  output logic      [1:0]       firstOff,
  output logic      [2:0]       count
);

  // Nibble i goes to stack pointer minus firstOff minus i
  always_comb begin
    frame    = 24'h000000;
    firstOff = 2'h1;
    count    = 3'h0;
    case (op)
      bcsu_pkg::OP_CALL_FAR, bcsu_pkg::OP_CALL_FAST: begin
        if (!modeTwo) begin
          frame = {8'h00, retAddr[11:8], memEn, regEn, retAddr[13:12],
                   retAddr[3:0], retAddr[7:4]};
          count = 3'h4;
        end else begin
          frame = {4'h0, retAddr[11:8], 2'h0, retAddr[13:12], retAddr[3:0],
                   retAddr[7:4], 2'h0, memEn, regEn};
          firstOff = 2'h2;
          count    = 3'h5;
        end
      end
      bcsu_pkg::OP_PUSH_PAIR: begin
        frame = {16'h0000, pairLow, pairHigh};
        count = 3'h2;
      end
      bcsu_pkg::OP_PUSH_BANKS: begin
        frame = {16'h0000, 2'h0, regSel, memSel};
        count = 3'h2;
      end
      default: begin
        count = 3'h0;
      end
    endcase
  end

endmodule // bcsu_frame_builder

/* tb/bcsu_stack_mem.sv */
// Nibble-wide stack memory model with registered reads
`timescale 1ns/1ps
module bcsu_stack_mem (
  input  wire logic       ref_clk,
  input  wire logic [7:0] memAddr,
  input  wire logic [3:0] memWrData,
  input  wire logic       memWrite,
  input  wire logic       memRead,
  output logic      [3:0] memRdData
);
  logic [3:0] mem [0:255];
  logic [1:0] hold;
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 4'h0;
    end
    hold = 2'h0;
    memRdData = 4'h0;
  end
  // Read data stands a short while, then churns
  always @(posedge ref_clk) begin
    if (memWrite) begin
      mem[memAddr] <= memWrData;
    end
    if (memRead) begin
      memRdData <= mem[memAddr];
      hold <= 2'h2;
    end else if (hold != 2'h0) begin
      hold <= hold - 2'h1;
    end else begin
      memRdData <= ~memRdData;
    end
  end
endmodule // bcsu_stack_mem

/* tb/branch_call_stack_unit_tb.sv */
// Self-checking bench for the branch, call and stack unit
`timescale 1ns/1ps
module branch_call_stack_unit_tb;
  logic ref_clk, srst, cmdValid, cmdReady, memBit, frameModeTwo, statusLoad;
  bcsu_pkg::bcsu_op_type cmdOp;
  logic [13:0] immAddr, curAddr, nextAddr, instructionPointer;
  logic [5:0]  relDisp;
  logic [3:0]  regB, regC, regD, regE, regX, regA, pushHigh, pushLow, memoryBankSelect;
  logic [3:0]  statusLoadHigh, statusLoadLow, statusWordHigh, statusWordLow;
  logic [3:0]  memWrData, memRdData, pairHigh, pairLow;
  logic [7:0]  stackPointer, memAddr;
  logic [1:0]  registerBankSelect;
  logic        carryFlag, memoryBankEnable, registerBankEnable, memWrite, memRead;
  logic        done, skipNext, pairLoad, sawSkip, sawPair;
  int          fails = 0;
  int          tests_run = 0;
  int          cycles = 0;

  bcsu_unit i_dut (.ref_clk, .srst, .cmdValid, .cmdOp, .cmdReady, .immAddr, .curAddr,
    .nextAddr, .relDisp, .memBit, .regB, .regC, .regD, .regE, .regX, .regA, .pushHigh,
    .pushLow, .memoryBankSelect, .registerBankSelect, .frameModeTwo, .statusLoad,
    .statusLoadHigh, .statusLoadLow, .instructionPointer, .stackPointer, .statusWordHigh,
    .statusWordLow, .carryFlag, .memoryBankEnable, .registerBankEnable, .memAddr, .memWrData,
    .memWrite, .memRead, .memRdData, .done, .skipNext, .pairLoad, .pairHigh, .pairLow);
  bcsu_stack_mem i_mem (.ref_clk, .memAddr, .memWrData, .memWrite, .memRead, .memRdData);

  initial ref_clk = 1'b0;
  always #10 ref_clk = ~ref_clk;

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      end_of_test();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Issue one command and wait for its done pulse
  task automatic run(input bcsu_pkg::bcsu_op_type op);
    int n = 0;
    @(posedge ref_clk);
    cmdValid <= 1'b1;
    cmdOp <= op;
    @(negedge ref_clk);
    while (cmdReady !== 1'b1) begin
      @(negedge ref_clk);
    end
    @(posedge ref_clk);
    cmdValid <= 1'b0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (done !== 1'b1 && n < 40);
    sawSkip = skipNext;
    sawPair = pairLoad;
    check(done, 1'b1);
  endtask

  task automatic load(input logic [3:0] hi, input logic [3:0] lo);
    @(posedge ref_clk);
    statusLoad <= 1'b1;
    statusLoadHigh <= hi;
    statusLoadLow <= lo;
    @(posedge ref_clk);
    statusLoad <= 1'b0;
  endtask

  task automatic jump(input bcsu_pkg::bcsu_op_type op, input logic [13:0] cur, nxt, imm,
                      input logic [5:0] disp, input logic [13:0] exp);
    @(posedge ref_clk);
    curAddr <= cur;
    nextAddr <= nxt;
    immAddr <= imm;
    relDisp <= disp;
    run(op);
    check(instructionPointer, exp);
  endtask

  initial begin
    srst = 1'b1; cmdValid = 1'b0; cmdOp = bcsu_pkg::OP_NONE; memBit = 1'b1;
    immAddr = 14'h0000; curAddr = 14'h0000; nextAddr = 14'h0000; relDisp = 6'h00;
    regB = 4'hE; regC = 4'h1; regD = 4'h5; regE = 4'h6; regX = 4'h9; regA = 4'hA;
    pushHigh = 4'h0; pushLow = 4'h0; memoryBankSelect = 4'h0; registerBankSelect = 2'h0;
    frameModeTwo = 1'b0; statusLoad = 1'b0; statusLoadHigh = 4'h0; statusLoadLow = 4'h0;
    repeat (6) @(posedge ref_clk);
    srst <= 1'b0;
    @(negedge ref_clk);
    check(instructionPointer, 14'h0000);
    check(stackPointer, 8'h00);
    check(cmdReady, 1'b1);
    load(4'h8, 4'h0);
    run(bcsu_pkg::OP_XOR_CARRY);
    check(carryFlag, 1'b0);
    run(bcsu_pkg::OP_XOR_CARRY);
    check(carryFlag, 1'b1);
    jump(bcsu_pkg::OP_JUMP_ABS, 14'h0000, 14'h0002, 14'h3FFF, 6'h00,
         14'h3FFF);
    jump(bcsu_pkg::OP_JUMP_REL, 14'h1000, 14'h1001, 14'h0000, 6'h31,
         14'h0FF1);
    jump(bcsu_pkg::OP_JUMP_REL, 14'h0FF8, 14'h0FF9, 14'h0000, 6'h10,
         14'h1008);
    jump(bcsu_pkg::OP_JUMP_BLOCK, 14'h2344, 14'h2346, 14'h0ABC, 6'h00,
         14'h2ABC);
    jump(bcsu_pkg::OP_JUMP_BLOCK, 14'h0FFE, 14'h1000, 14'h0ABC, 6'h00,
         14'h1ABC);
    jump(bcsu_pkg::OP_PAGE_DE, 14'h1232, 14'h1234, 14'h0000, 6'h00,
         14'h1256);
    jump(bcsu_pkg::OP_PAGE_DE, 14'h12FE, 14'h1300, 14'h0000, 6'h00,
         14'h1356);
    jump(bcsu_pkg::OP_PAGE_XA, 14'h12FF, 14'h1301, 14'h0000, 6'h00,
         14'h139A);
    jump(bcsu_pkg::OP_JUMP_BCDE, 14'h0000, 14'h0002, 14'h0000, 6'h00,
         14'h2156);
    jump(bcsu_pkg::OP_JUMP_BCXA, 14'h0000, 14'h0002, 14'h0000, 6'h00,
         14'h219A);
    load(4'h8, 4'h3);
    jump(bcsu_pkg::OP_CALL_FAR, 14'h0000, 14'h2A5C, 14'h0123, 6'h00,
         14'h0123);
    check(stackPointer, 8'hFC);
    // Last nibble lands in memory one edge after done
    @(negedge ref_clk);
    check(i_mem.mem[8'hFF], 4'h5);
    check(i_mem.mem[8'hFE], 4'hC);
    check(i_mem.mem[8'hFD], 4'hE);
    check(i_mem.mem[8'hFC], 4'hA);
    load(4'h8, 4'h0);
    run(bcsu_pkg::OP_EXIT);
    check(instructionPointer, 14'h2A5C);
    check(stackPointer, 8'h00);
    check(statusWordLow, 4'h3);
    check(memoryBankEnable, 1'b1);
    check(registerBankEnable, 1'b1);
    check(statusWordHigh, 4'h8);
    check(sawSkip, 1'b0);
    @(posedge ref_clk);
    frameModeTwo <= 1'b1;
    load(4'h0, 4'h2);
    jump(bcsu_pkg::OP_CALL_FAST, 14'h0000, 14'h1B7D, 14'h3FFF, 6'h00,
         14'h07FF);
    check(stackPointer, 8'hFA);
    @(negedge ref_clk);
    check(i_mem.mem[8'hFF], 4'h5);
    check(i_mem.mem[8'hFE], 4'h2);
    check(i_mem.mem[8'hFD], 4'h7);
    check(i_mem.mem[8'hFC], 4'hD);
    check(i_mem.mem[8'hFB], 4'h1);
    check(i_mem.mem[8'hFA], 4'hB);
    load(4'h8, 4'h1);
    run(bcsu_pkg::OP_EXIT_SKIP);
    check(sawSkip, 1'b1);
    check(instructionPointer, 14'h1B7D);
    check(stackPointer, 8'h00);
    check(statusWordLow, 4'h2);
    check(memoryBankEnable, 1'b1);
    check(registerBankEnable, 1'b0);
    check(statusWordHigh, 4'h8);
    @(posedge ref_clk);
    frameModeTwo <= 1'b0;
    pushHigh <= 4'h8;
    pushLow <= 4'h1;
    run(bcsu_pkg::OP_PUSH_PAIR);
    check(stackPointer, 8'hFE);
    @(negedge ref_clk);
    check(i_mem.mem[8'hFF], 4'h8);
    check(i_mem.mem[8'hFE], 4'h1);
    load(4'h0, 4'h0);
    jump(bcsu_pkg::OP_CALL_FAR, 14'h0000, 14'h0456, 14'h0100, 6'h00,
         14'h0100);
    run(bcsu_pkg::OP_EXIT_INT);
    check(instructionPointer, 14'h0456);
    check(statusWordLow, 4'h1);
    check(statusWordHigh, 4'h8);
    check(stackPointer, 8'h00);
    @(posedge ref_clk);
    memoryBankSelect <= 4'hF;
    registerBankSelect <= 2'h2;
    run(bcsu_pkg::OP_PUSH_BANKS);
    check(stackPointer, 8'hFE);
    @(negedge ref_clk);
    check(i_mem.mem[8'hFF], 4'hF);
    check(i_mem.mem[8'hFE], 4'h2);
    run(bcsu_pkg::OP_POP_PAIR);
    check(sawPair, 1'b1);
    check(stackPointer, 8'h00);
    check(pairLow, 4'h2);
    check(pairHigh, 4'hF);
    end_of_test();
  end
endmodule // branch_call_stack_unit_tb
